// ===== bench/diskette_ctrl_host_regs_bench.sv
module diskette_ctrl_host_regs_bench;
    timeunit 1ns;
    timeprecision 1ns;
    localparam logic [7:0] ID2 = 8'h5A; // Arbitrary identification value.
    logic ref_clk_i = 1'b0;
    logic rst_b_i = 1'b0;
    logic [9:0] addr_i = 10'h000;
    logic [7:0] wdata_i = 8'h00;
    logic wr_i = 1'b0, rd_i = 1'b0, kick = 1'b0, xs = 1'b0, cv = 1'b0;
    logic done = 1'b0, wr_en = 1'b1, non_dma = 1'b1, dchg = 1'b1;
    logic [7:0] lvl = 8'hB6, lines, rdata_o, cmd_byte_o;
    logic [3:0] motor_en_o;
    logic [1:0] drive_sel_o, rate_o, clk_sel, r;
    logic [2:0] precomp_o, p, st;
    logic ctrl_reset_b_o, cmd_stb_o, core_rdy_o, rdb;
    logic wdb = 1'b1, th = 1'b1, crdy = 1'b0, rv = 1'b0, cvo, rr;
    logic [5:0] id_bits = 6'h19;
    logic [3:0] seek = 4'h5;
    logic [7:0] rb = 8'h00, cdo;
    int n_mismatch = 0;
    int comparisons = 0;

    always #10 ref_clk_i = ~ref_clk_i;

    drive_cable_model cable (.ref_clk_i(ref_clk_i), .lvl_i(lvl),
        .kick_i(kick), .lines_o(lines), .rd_data_b_o(rdb));

    diskette_ctrl_host_regs #(.TYPE2(1'b1), .ID_TYPE2(ID2)) DUT (
        .ref_clk_i(ref_clk_i), .rst_b_i(rst_b_i), .addr_i(addr_i),
        .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
        .irq_pending_i(lines[7]), .second_drive_b_i(lines[6]),
        .step_i(lines[5]), .track0_b_i(lines[4]), .head1_i(lines[3]),
        .index_b_i(lines[2]), .wprot_b_i(lines[1]), .dir_in_i(lines[0]),
        .wr_data_b_i(wdb), .rd_data_b_i(rdb), .wr_en_i(wr_en),
        .media_type_i(id_bits[5:4]), .drive_type_i(id_bits[3:2]),
        .startup_drive_i(id_bits[1:0]),
        .non_dma_i(non_dma), .seek_busy_i(seek), .disk_change_i(dchg),
        .motor_en_o(motor_en_o), .drive_sel_o(drive_sel_o),
        .ctrl_reset_b_o(ctrl_reset_b_o), .rate_o(rate_o),
        .precomp_o(precomp_o), .ctrl_clk_sel_o(clk_sel),
        .cmd_byte_o(cmd_byte_o), .cmd_stb_o(cmd_stb_o),
        .xfer_start_i(xs), .xfer_to_host_i(th), .core_dat_i(8'h3C),
        .core_vld_i(cv), .core_rdy_o(core_rdy_o), .core_dat_o(cdo),
        .core_vld_o(cvo), .core_rdy_i(crdy), .res_byte_i(rb),
        .res_vld_i(rv), .res_rdy_o(rr), .cmd_done_i(done));

    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        comparisons++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic wr(input logic [9:0] a, input logic [7:0] d);
        @(posedge ref_clk_i);
        addr_i <= a;
        wdata_i <= d;
        wr_i <= 1'b1;
        @(posedge ref_clk_i);
        wr_i <= 1'b0;
        @(negedge ref_clk_i);
    endtask

    task automatic rd(input logic [9:0] a, input logic [7:0] exp);
        @(posedge ref_clk_i);
        addr_i <= a;
        rd_i <= 1'b1;
        @(posedge ref_clk_i);
        rd_i <= 1'b0;
        @(negedge ref_clk_i);
        chk(rdata_o, exp);
    endtask

    task automatic wr_rd(input logic [9:0] wa, input logic [7:0] d,
        input logic [9:0] ra, input logic [7:0] exp);
        @(posedge ref_clk_i);
        addr_i <= wa;
        wdata_i <= d;
        wr_i <= 1'b1;
        @(posedge ref_clk_i);
        wr_i <= 1'b0;
        addr_i <= ra;
        rd_i <= 1'b1;
        @(posedge ref_clk_i);
        rd_i <= 1'b0;
        @(negedge ref_clk_i);
        chk(rdata_o, exp);
    endtask

    task automatic test_done;
        $display("Comparisons %0d, mismatches %0d", comparisons, n_mismatch);
        if (n_mismatch == 0 && comparisons > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    task automatic t_reset;
        rd(fdc_pkg::OFS_DCR, 8'h00);
        rd(fdc_pkg::OFS_RSVD, 8'h00);
        wr(fdc_pkg::OFS_RSVD, 8'hFF);
        rd(fdc_pkg::OFS_DCR, 8'h00);
        repeat (180) @(posedge ref_clk_i);
        $display("test reset done");
    endtask

    task automatic t_dcr;
        wr_rd(fdc_pkg::OFS_DCR, 8'hFD, fdc_pkg::OFS_DCR, 8'hFD);
        chk({motor_en_o, 1'b0, ctrl_reset_b_o, drive_sel_o}, 8'hF5);
        wr(fdc_pkg::OFS_DCR, 8'h3D);
        chk({motor_en_o, 1'b0, ctrl_reset_b_o, drive_sel_o}, 8'h35);
        $display("test drive control done");
    endtask

    task automatic t_status;
        rd(fdc_pkg::OFS_STAT_A, 8'hB6);
        @(posedge ref_clk_i);
        kick <= 1'b1;
        wdb <= 1'b0;
        @(posedge ref_clk_i);
        kick <= 1'b0;
        wdb <= 1'b1;
        repeat (2) @(posedge ref_clk_i);
        rd(fdc_pkg::OFS_STAT_B, 8'h3F);
        rd(fdc_pkg::OFS_DRV_ID, 8'h64);
        rd(fdc_pkg::OFS_MSR, 8'hA5);
        $display("test status done");
    endtask

    task automatic t_rate;
        for (int i = 0; i < 32; i++)
        begin
            r = i[4:3];
            p = i[2:0];
            st = (p == 3'h7) ? 3'h0 : (p != 3'h0) ? p :
                (r == 2'h3) ? 3'h1 : 3'h3;
            wr(fdc_pkg::OFS_MSR, {3'h0, p, r});
            chk({3'h0, rate_o, precomp_o}, {3'h0, r, st});
            chk({6'h0, clk_sel}, {6'h0, fdc_pkg::CLK_24MHZ});
            if (p == 3'h7)
                rd(fdc_pkg::OFS_RATE,
                    {dchg, 4'h0, r, r == 2'h1 || r == 2'h2});
        end
        wr(fdc_pkg::OFS_RATE, 8'h01);
        chk({6'h0, rate_o}, 8'h01);
        $display("test rate done");
    endtask

    task automatic t_unlock;
        wr(fdc_pkg::OFS_DATA, fdc_pkg::OP_UNLOCK);
        rd(fdc_pkg::OFS_MSR, 8'hF5);
        rd(fdc_pkg::OFS_DATA, ID2);
        rd(fdc_pkg::OFS_MSR, 8'hA5);
        wr_rd(fdc_pkg::OFS_DATA, fdc_pkg::OP_UNLOCK,
            fdc_pkg::OFS_DATA, ID2);
        $display("test unlock done");
    endtask

    task automatic t_xfer;
        wr(fdc_pkg::OFS_DATA, 8'h03);
        chk({cmd_stb_o, cmd_byte_o[6:0]}, 8'h83);
        @(posedge ref_clk_i);
        xs <= 1'b1;
        @(posedge ref_clk_i);
        xs <= 1'b0;
        cv <= 1'b1;
        @(negedge ref_clk_i);
        chk({7'h0, core_rdy_o}, 8'h01);
        @(posedge ref_clk_i);
        cv <= 1'b0;
        @(negedge ref_clk_i);
        chk({7'h0, core_rdy_o}, 8'h00);
        rd(fdc_pkg::OFS_MSR, 8'hF5);
        rd(fdc_pkg::OFS_DATA, 8'h3C);
        chk({7'h0, rr}, 8'h01);
        @(posedge ref_clk_i);
        rb <= 8'hC3;
        rv <= 1'b1;
        @(posedge ref_clk_i);
        rv <= 1'b0;
        rd(fdc_pkg::OFS_MSR, 8'hF5);
        rd(fdc_pkg::OFS_DATA, 8'hC3);
        rd(fdc_pkg::OFS_MSR, 8'h75);
        @(posedge ref_clk_i);
        done <= 1'b1;
        @(posedge ref_clk_i);
        done <= 1'b0;
        rd(fdc_pkg::OFS_MSR, 8'hA5);
        $display("test transfer done");
    endtask

    task automatic t_to_core;
        wr(fdc_pkg::OFS_DATA, fdc_pkg::OP_CONFIGURE);
        wr(fdc_pkg::OFS_DATA, 8'h00);
        wr(fdc_pkg::OFS_DATA, 8'h20);
        wr(fdc_pkg::OFS_DATA, 8'h00);
        rd(fdc_pkg::OFS_MSR, 8'hA5);
        wr(fdc_pkg::OFS_DATA, 8'h05);
        @(posedge ref_clk_i);
        th <= 1'b0;
        xs <= 1'b1;
        @(posedge ref_clk_i);
        xs <= 1'b0;
        wr(fdc_pkg::OFS_DATA, 8'h77);
        wr(fdc_pkg::OFS_DATA, 8'h78);
        rd(fdc_pkg::OFS_MSR, 8'hB5);
        chk({7'h0, cvo}, 8'h01);
        chk(cdo, 8'h77);
        @(posedge ref_clk_i);
        crdy <= 1'b1;
        @(posedge ref_clk_i);
        crdy <= 1'b0;
        @(negedge ref_clk_i);
        chk(cdo, 8'h78);
        @(posedge ref_clk_i);
        done <= 1'b1;
        @(posedge ref_clk_i);
        done <= 1'b0;
        rd(fdc_pkg::OFS_MSR, 8'hA5);
        $display("test transfer to core done");
    endtask

    initial
    begin
        #200000;
        n_mismatch++;
        test_done();
    end

    initial
    begin
        repeat (16) @(posedge ref_clk_i);
        rst_b_i <= 1'b1;
        t_reset();
        t_dcr();
        t_status();
        t_rate();
        t_unlock();
        t_xfer();
        t_to_core();
        test_done();
    end
endmodule

// ===== bench/drive_cable_model.sv
module drive_cable_model (
    input wire logic ref_clk_i,
    input wire logic [7:0] lvl_i,
    input wire logic kick_i,
    output logic [7:0] lines_o,
    output logic rd_data_b_o
);
    timeunit 1ns;
    timeprecision 1ns;
    assign lines_o = lvl_i;
    // The read strobe idles high; a kick gives one low cycle, so one rise.
    always_ff @(posedge ref_clk_i)
    begin
        rd_data_b_o <= !kick_i;
    end
endmodule

// ===== verilog/diskette_ctrl_host_regs.sv
module diskette_ctrl_host_regs #(
    parameter bit TYPE2 = 1'b1,
    parameter int FIFO_DEPTH = fdc_pkg::FIFO_DEPTH,
    parameter logic [7:0] ID_TYPE1 = 8'hA5,
    parameter logic [7:0] ID_TYPE2 = 8'h5A
) (
    input wire logic ref_clk_i,
    input wire logic rst_b_i,
    input wire logic [9:0] addr_i,
    input wire logic [7:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [7:0] rdata_o,
    input wire logic irq_pending_i,
    input wire logic second_drive_b_i,
    input wire logic step_i,
    input wire logic track0_b_i,
    input wire logic head1_i,
    input wire logic index_b_i,
    input wire logic wprot_b_i,
    input wire logic dir_in_i,
    input wire logic wr_data_b_i,
    input wire logic rd_data_b_i,
    input wire logic wr_en_i,
    input wire logic [1:0] media_type_i,
    input wire logic [1:0] drive_type_i,
    input wire logic [1:0] startup_drive_i,
    input wire logic non_dma_i,
    input wire logic [3:0] seek_busy_i,
    input wire logic disk_change_i,
    output logic [3:0] motor_en_o,
    output logic [1:0] drive_sel_o,
    output logic ctrl_reset_b_o,
    output logic [1:0] rate_o,
    output logic [2:0] precomp_o,
    output logic [1:0] ctrl_clk_sel_o,
    output logic [7:0] cmd_byte_o,
    output logic cmd_stb_o,
    input wire logic xfer_start_i,
    input wire logic xfer_to_host_i,
    input wire logic [7:0] core_dat_i,
    input wire logic core_vld_i,
    output logic core_rdy_o,
    output logic [7:0] core_dat_o,
    output logic core_vld_o,
    input wire logic core_rdy_i,
    input wire logic [7:0] res_byte_i,
    input wire logic res_vld_i,
    output logic res_rdy_o,
    input wire logic cmd_done_i
);
    localparam int AW = $clog2(FIFO_DEPTH);

    typedef struct packed {
        logic [7:0] dcr;
        logic [1:0] rate;
        logic [2:0] pc_field;
        logic fifo_en;
        logic [1:0] pidx;
        logic to_host;
        logic [7:0] res;
        logic res_full;
        logic res_local;
        logic wd_tog;
        logic rd_tog;
        logic wd_prev;
        logic rd_prev;
        logic [7:0] rdata;
        logic [7:0] cmd_byte;
        logic cmd_stb;
        fdc_pkg::phase_t phase;
    } regs_t;

    regs_t s_r;
    regs_t s_nxt;
    logic fifo_push;
    logic fifo_pop;
    logic fifo_flush;
    logic [7:0] fifo_wdata;
    logic [7:0] fifo_head;
    logic fifo_full;
    logic fifo_empty;
    logic [AW:0] fifo_limit;
    logic rqm;
    logic dio;
    logic wr_data_port;
    logic rd_data_port;
    logic [7:0] msr;

    function automatic logic [1:0] clk_for_rate(input logic [1:0] rate);
        if (TYPE2)
            return fdc_pkg::CLK_24MHZ;
        else if (rate == fdc_pkg::RATE_500)
            return fdc_pkg::CLK_8MHZ;
        else
            return fdc_pkg::CLK_4MHZ;
    endfunction

    function automatic logic [1:0] rate_from_host(input logic [1:0] bits);
        // The basic variant only knows 500 and 250 kbps.
        if (TYPE2)
            return bits;
        else
            return {bits[1], 1'b0};
    endfunction

    precomp_decode #(
        .TYPE2(TYPE2)
    ) u_precomp (
        .rate_i(s_r.rate),
        .field_i(s_r.pc_field),
        .steps_o(precomp_o)
    );

    xfer_fifo #(
        .W(8),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .ref_clk_i(ref_clk_i),
        .rst_b_i(rst_b_i),
        .flush_i(fifo_flush),
        .limit_i(fifo_limit),
        .push_i(fifo_push),
        .wdata_i(fifo_wdata),
        .pop_i(fifo_pop),
        .head_o(fifo_head),
        .full_o(fifo_full),
        .empty_o(fifo_empty)
    );

    // With the FIFO disabled the storage holds one byte, as the basic part.
    assign fifo_limit = (TYPE2 && s_r.fifo_en) ?
        (AW + 1)'(FIFO_DEPTH) : (AW + 1)'(1);

    always_comb
    begin
        unique case (s_r.phase)
            fdc_pkg::PH_IDLE, fdc_pkg::PH_PARAM, fdc_pkg::PH_CORE:
                rqm = 1'b1;
            fdc_pkg::PH_XFER:
                rqm = s_r.to_host ? !fifo_empty : !fifo_full;
            fdc_pkg::PH_RESULT:
                rqm = s_r.res_full;
            default:
                rqm = 1'b0;
        endcase
    end

    assign dio = (s_r.phase == fdc_pkg::PH_RESULT) ||
        (s_r.phase == fdc_pkg::PH_XFER && s_r.to_host);
    assign msr = {rqm, dio, non_dma_i,
        s_r.phase != fdc_pkg::PH_IDLE, seek_busy_i};
    assign wr_data_port = wr_i && addr_i == fdc_pkg::OFS_DATA && rqm && !dio;
    assign rd_data_port = rd_i && addr_i == fdc_pkg::OFS_DATA && rqm && dio;

    assign core_rdy_o = s_r.phase == fdc_pkg::PH_XFER && s_r.to_host &&
        !fifo_full;
    assign core_vld_o = s_r.phase == fdc_pkg::PH_XFER && !s_r.to_host &&
        !fifo_empty;
    assign core_dat_o = fifo_head;
    assign res_rdy_o = (s_r.phase == fdc_pkg::PH_CORE ||
        s_r.phase == fdc_pkg::PH_XFER || s_r.phase == fdc_pkg::PH_RESULT) &&
        !s_r.res_full && !s_r.res_local;

    always_comb
    begin
        s_nxt = s_r;
        s_nxt.rdata = '0;
        s_nxt.cmd_stb = 1'b0;
        fifo_push = 1'b0;
        fifo_pop = 1'b0;
        fifo_flush = 1'b0;
        fifo_wdata = s_r.to_host ? core_dat_i : wdata_i;

        // Both strobes are edge detected on their rising, inactive edge.
        s_nxt.wd_prev = wr_data_b_i;
        s_nxt.rd_prev = rd_data_b_i;
        if (wr_data_b_i && !s_r.wd_prev)
            s_nxt.wd_tog = !s_r.wd_tog;
        if (rd_data_b_i && !s_r.rd_prev)
            s_nxt.rd_tog = !s_r.rd_tog;

        if (wr_i)
        begin
            unique case (addr_i)
                fdc_pkg::OFS_DCR:
                    s_nxt.dcr = TYPE2 ? wdata_i :
                        (wdata_i & fdc_pkg::DCR_MASK_T1);
                fdc_pkg::OFS_MSR:
                    if (TYPE2)
                    begin
                        s_nxt.rate =
                            wdata_i[fdc_pkg::PSR_RATE_LSB +: 2];
                        s_nxt.pc_field =
                            wdata_i[fdc_pkg::PSR_PC_LSB +: 3];
                    end
                fdc_pkg::OFS_RATE:
                    s_nxt.rate = rate_from_host(wdata_i[1:0]);
                default:
                    s_nxt.rate = s_r.rate;
            endcase
        end

        if (rd_i)
        begin
            unique case (addr_i)
                fdc_pkg::OFS_STAT_A:
                    s_nxt.rdata = {irq_pending_i, second_drive_b_i, step_i,
                        track0_b_i, head1_i, index_b_i, wprot_b_i,
                        dir_in_i};
                fdc_pkg::OFS_STAT_B:
                    s_nxt.rdata = {2'h0, s_r.dcr[fdc_pkg::DCR_SEL0_BIT],
                        s_r.wd_tog, s_r.rd_tog, wr_en_i,
                        s_r.dcr[fdc_pkg::DCR_MOT1_BIT],
                        s_r.dcr[fdc_pkg::DCR_MOT0_BIT]};
                fdc_pkg::OFS_DCR:
                    s_nxt.rdata = s_r.dcr;
                fdc_pkg::OFS_DRV_ID:
                    s_nxt.rdata = TYPE2 ? {media_type_i, drive_type_i,
                        startup_drive_i, 2'h0} : '0;
                fdc_pkg::OFS_MSR:
                    s_nxt.rdata = msr;
                fdc_pkg::OFS_RATE:
                    s_nxt.rdata = {disk_change_i, 4'h0, s_r.rate,
                        s_r.rate == fdc_pkg::RATE_250 ||
                        s_r.rate == fdc_pkg::RATE_300};
                default:
                    s_nxt.rdata = '0;
            endcase
        end

        // Result bytes always pass one at a time through the result holder.
        if (rd_data_port)
        begin
            if (s_r.phase == fdc_pkg::PH_RESULT)
            begin
                s_nxt.rdata = s_r.res;
                s_nxt.res_full = 1'b0;
                if (s_r.res_local)
                begin
                    s_nxt.res_local = 1'b0;
                    s_nxt.phase = fdc_pkg::PH_IDLE;
                end
            end
            else
            begin
                s_nxt.rdata = fifo_head;
                fifo_pop = 1'b1;
            end
        end

        if (wr_data_port)
        begin
            unique case (s_r.phase)
                fdc_pkg::PH_IDLE:
                    if (wdata_i == fdc_pkg::OP_UNLOCK)
                    begin
                        s_nxt.res = TYPE2 ? ID_TYPE2 : ID_TYPE1;
                        s_nxt.res_full = 1'b1;
                        s_nxt.res_local = 1'b1;
                        s_nxt.phase = fdc_pkg::PH_RESULT;
                    end
                    else if (TYPE2 && wdata_i == fdc_pkg::OP_CONFIGURE)
                    begin
                        s_nxt.pidx = '0;
                        s_nxt.phase = fdc_pkg::PH_PARAM;
                    end
                    else
                    begin
                        s_nxt.cmd_byte = wdata_i;
                        s_nxt.cmd_stb = 1'b1;
                        s_nxt.phase = fdc_pkg::PH_CORE;
                    end
                fdc_pkg::PH_PARAM:
                begin
                    if (s_r.pidx == fdc_pkg::CFG_EFF_IDX)
                        s_nxt.fifo_en = wdata_i[fdc_pkg::CFG_EFF_BIT];
                    s_nxt.pidx = 2'(s_r.pidx + 1'b1);
                    if (2'(s_r.pidx + 1'b1) == fdc_pkg::CFG_PARAMS)
                        s_nxt.phase = fdc_pkg::PH_IDLE;
                end
                fdc_pkg::PH_CORE:
                begin
                    s_nxt.cmd_byte = wdata_i;
                    s_nxt.cmd_stb = 1'b1;
                end
                fdc_pkg::PH_XFER:
                    fifo_push = 1'b1;
                default:
                    s_nxt.phase = s_r.phase;
            endcase
        end

        if (core_vld_i && core_rdy_o)
            fifo_push = 1'b1;
        if (core_vld_o && core_rdy_i)
            fifo_pop = 1'b1;

        if (xfer_start_i && s_r.phase == fdc_pkg::PH_CORE)
        begin
            s_nxt.to_host = xfer_to_host_i;
            s_nxt.phase = fdc_pkg::PH_XFER;
            fifo_flush = 1'b1;
        end
        if (res_vld_i && res_rdy_o)
        begin
            s_nxt.res = res_byte_i;
            s_nxt.res_full = 1'b1;
            s_nxt.phase = fdc_pkg::PH_RESULT;
        end
        if (cmd_done_i && s_r.phase != fdc_pkg::PH_IDLE &&
            s_r.phase != fdc_pkg::PH_PARAM && !s_r.res_local)
            s_nxt.phase = fdc_pkg::PH_IDLE;

        // The register bit is low-true, so a reset value of zero holds the
        // controller in reset until software releases it.
        if (!s_r.dcr[fdc_pkg::DCR_RST_BIT])
        begin
            s_nxt.phase = fdc_pkg::PH_IDLE;
            s_nxt.res_full = 1'b0;
            s_nxt.res_local = 1'b0;
            s_nxt.cmd_stb = 1'b0;
            fifo_flush = 1'b1;
        end
    end

    always_ff @(posedge ref_clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            s_r <= '0;
            s_r.dcr <= fdc_pkg::DCR_RESET;
            // Data strobes idle high, so no false edge follows reset.
            s_r.wd_prev <= 1'b1;
            s_r.rd_prev <= 1'b1;
        end
        else
            s_r <= s_nxt;
    end

    assign rdata_o = s_r.rdata;
    assign motor_en_o = s_r.dcr[7:4];
    assign drive_sel_o = s_r.dcr[1:0];
    assign ctrl_reset_b_o = s_r.dcr[fdc_pkg::DCR_RST_BIT];
    assign rate_o = s_r.rate;
    assign ctrl_clk_sel_o = clk_for_rate(s_r.rate);
    assign cmd_byte_o = s_r.cmd_byte;
    assign cmd_stb_o = s_r.cmd_stb;

    default clocking cb @(posedge ref_clk_i);
    endclocking
    default disable iff (!rst_b_i);

    sequence s_unlock;
        wr_i && addr_i == fdc_pkg::OFS_DATA && ctrl_reset_b_o &&
            s_r.phase == fdc_pkg::PH_IDLE && wdata_i == fdc_pkg::OP_UNLOCK;
    endsequence
    sequence s_read_data;
        rd_i && addr_i == fdc_pkg::OFS_DATA;
    endsequence

    a_unlock_id: assert property (s_unlock ##1 s_read_data |=>
        rdata_o == (TYPE2 ? ID_TYPE2 : ID_TYPE1) &&
        s_r.phase == fdc_pkg::PH_IDLE)
        else $error("unlock did not return the variant code");
    a_xfer_flush: assert property (xfer_start_i && ctrl_reset_b_o &&
        s_r.phase == fdc_pkg::PH_CORE |=> fifo_empty &&
        s_r.phase == fdc_pkg::PH_XFER)
        else $error("fifo not empty on data phase entry");
    a_fifo_single: assert property (!s_r.fifo_en |->
        u_fifo.s_r.cnt <= 1)
        else $error("fifo held more than one byte while disabled");
    a_precomp_map: assert property (TYPE2 &&
        s_r.pc_field == fdc_pkg::PC_DEFAULT |->
        precomp_o == (s_r.rate == fdc_pkg::RATE_1000 ?
        fdc_pkg::STEPS_41 : fdc_pkg::STEPS_125))
        else $error("default precompensation wrong");
    a_clk_follow: assert property (wr_i && addr_i == fdc_pkg::OFS_RATE
        |=> ctrl_clk_sel_o == (TYPE2 ? fdc_pkg::CLK_24MHZ :
        ($past(wdata_i[1]) ? fdc_pkg::CLK_4MHZ : fdc_pkg::CLK_8MHZ)))
        else $error("controller clock did not follow rate");
    a_dcr_write: assert property (wr_i && addr_i == fdc_pkg::OFS_DCR
        ##1 rd_i && addr_i == fdc_pkg::OFS_DCR |=>
        rdata_o == (TYPE2 ? $past(wdata_i, 2) :
        ($past(wdata_i, 2) & fdc_pkg::DCR_MASK_T1)))
        else $error("drive control read back mismatch");
    a_rsvd_write: assert property (wr_i && addr_i == fdc_pkg::OFS_RSVD
        |=> $stable(s_r.dcr) && $stable(s_r.rate) && $stable(s_r.pc_field))
        else $error("reserved write changed a register");
    a_rd_toggle: assert property (rd_data_b_i && !s_r.rd_prev |=>
        s_r.rd_tog != $past(s_r.rd_tog))
        else $error("read data toggle missed an edge");
    a_msr_busy: assert property (rd_i && addr_i == fdc_pkg::OFS_MSR |=>
        rdata_o[4] == ($past(s_r.phase) != fdc_pkg::PH_IDLE) &&
        rdata_o[3:0] == $past(seek_busy_i))
        else $error("main status busy bits wrong");
    a_soft_reset: assert property (!ctrl_reset_b_o [*2] |->
        s_r.phase == fdc_pkg::PH_IDLE && fifo_empty)
        else $error("controller reset did not idle the engine");
endmodule

// ===== verilog/fdc_pkg.sv
package fdc_pkg;
    // Register offsets on the host port.
    localparam logic [9:0] OFS_STAT_A = 10'h3F0;
    localparam logic [9:0] OFS_STAT_B = 10'h3F1;
    localparam logic [9:0] OFS_DCR = 10'h3F2;
    localparam logic [9:0] OFS_DRV_ID = 10'h3F3;
    localparam logic [9:0] OFS_MSR = 10'h3F4;
    localparam logic [9:0] OFS_DATA = 10'h3F5;
    localparam logic [9:0] OFS_RSVD = 10'h3F6;
    localparam logic [9:0] OFS_RATE = 10'h3F7;

    // Drive control fields.
    localparam logic [7:0] DCR_RESET = 8'h00;
    localparam logic [7:0] DCR_MASK_T1 = 8'h3D;
    localparam int DCR_RST_BIT = 2;
    localparam int DCR_SEL0_BIT = 0;
    localparam int DCR_MOT0_BIT = 4;
    localparam int DCR_MOT1_BIT = 5;

    // Precompensation select fields.
    localparam int PSR_RATE_LSB = 0;
    localparam int PSR_PC_LSB = 2;

    // Data rate codes.
    localparam logic [1:0] RATE_500 = 2'h0;
    localparam logic [1:0] RATE_300 = 2'h1;
    localparam logic [1:0] RATE_250 = 2'h2;
    localparam logic [1:0] RATE_1000 = 2'h3;

    // Precompensation field codes and delays in 41.7 ns steps.
    localparam int PRECOMP_STEP_PS = 41700;
    localparam logic [2:0] PC_DEFAULT = 3'h0;
    localparam logic [2:0] PC_ZERO = 3'h7;
    localparam logic [2:0] STEPS_NONE = 3'h0;
    localparam logic [2:0] STEPS_41 = 3'h1;
    localparam logic [2:0] STEPS_125 = 3'h3;

    // Command bytes handled inside this block.
    localparam logic [7:0] OP_UNLOCK = 8'h94;
    localparam logic [7:0] OP_CONFIGURE = 8'h13;
    localparam logic [1:0] CFG_PARAMS = 2'h3;
    localparam logic [1:0] CFG_EFF_IDX = 2'h1;
    localparam int CFG_EFF_BIT = 5;

    localparam int FIFO_DEPTH = 16;

    typedef enum logic [1:0] {
        CLK_4MHZ = 2'h0,
        CLK_8MHZ = 2'h1,
        CLK_24MHZ = 2'h2
    } ctrl_clk_t;

    typedef enum logic [2:0] {
        PH_IDLE = 3'h0,
        PH_PARAM = 3'h1,
        PH_CORE = 3'h2,
        PH_XFER = 3'h3,
        PH_RESULT = 3'h4
    } phase_t;
endpackage

// ===== verilog/precomp_decode.sv
module precomp_decode #(
    parameter bit TYPE2 = 1'b1
) (
    input wire logic [1:0] rate_i,
    input wire logic [2:0] field_i,
    output logic [2:0] steps_o
);
    always_comb
    begin
        if (!TYPE2)
            steps_o = fdc_pkg::STEPS_125;
        else if (field_i == fdc_pkg::PC_ZERO)
            steps_o = fdc_pkg::STEPS_NONE;
        else if (field_i != fdc_pkg::PC_DEFAULT)
            steps_o = field_i;
        else if (rate_i == fdc_pkg::RATE_1000)
            steps_o = fdc_pkg::STEPS_41;
        else
            steps_o = fdc_pkg::STEPS_125;
    end
endmodule

// ===== verilog/xfer_fifo.sv
module xfer_fifo #(
    parameter int W = 8,
    parameter int DEPTH = 16,
    localparam int AW = $clog2(DEPTH)
) (
    input wire logic ref_clk_i,
    input wire logic rst_b_i,
    input wire logic flush_i,
    input wire logic [AW:0] limit_i,
    input wire logic push_i,
    input wire logic [W-1:0] wdata_i,
    input wire logic pop_i,
    output logic [W-1:0] head_o,
    output logic full_o,
    output logic empty_o
);
    typedef struct packed {
        logic [DEPTH-1:0][W-1:0] mem;
        logic [AW-1:0] wp;
        logic [AW-1:0] rp;
        logic [AW:0] cnt;
    } fifo_t;

    fifo_t s_r;
    fifo_t s_nxt;
    logic do_push;
    logic do_pop;

    // The limit lets the same storage act as a single byte latch.
    assign full_o = s_r.cnt >= limit_i;
    assign empty_o = s_r.cnt == '0;
    assign head_o = s_r.mem[s_r.rp];
    assign do_push = push_i && !full_o;
    assign do_pop = pop_i && !empty_o;

    always_comb
    begin
        s_nxt = s_r;
        if (flush_i)
        begin
            s_nxt.wp = '0;
            s_nxt.rp = '0;
            s_nxt.cnt = '0;
        end
        else
        begin
            if (do_push)
            begin
                s_nxt.mem[s_r.wp] = wdata_i;
                s_nxt.wp = AW'(s_r.wp + 1'b1);
            end
            if (do_pop)
                s_nxt.rp = AW'(s_r.rp + 1'b1);
            if (do_push && !do_pop)
                s_nxt.cnt = (AW + 1)'(s_r.cnt + 1'b1);
            else if (do_pop && !do_push)
                s_nxt.cnt = (AW + 1)'(s_r.cnt - 1'b1);
        end
    end

    always_ff @(posedge ref_clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
            s_r <= '0;
        else
            s_r <= s_nxt;
    end
endmodule
